//--- rtl/sap_checker.sv
// Request checker, abort coder and process data framer of the object server
`default_nettype none
module sap_checker
(
   input  wire logic              clk,          // 20 MHz clock
   input  wire logic              arst_n,       // Asynchronous reset, active low
   input  wire sap_pkg::sap_nmt_t nmt_state,    // Current network state
   input  wire logic              req_valid,    // Request frame present, one cycle
   input  wire logic [63:0]       req_data,     // Request bytes, byte 0 in [7:0]
   input  wire logic              obj_idx_ok,   // Addressed index exists
   input  wire logic              obj_sub_ok,   // Addressed subindex exists
   input  wire logic              obj_ro,       // Addressed entry is constant or read-only
   input  wire logic [2:0]        obj_size,     // Entry size in bytes, 0 for variable
   input  wire logic              obj_ranged,   // Entry has min and max limits
   input  wire logic [31:0]       obj_min,      // Lowest allowed value
   input  wire logic [31:0]       obj_max,      // Highest allowed value
   input  wire logic              obj_fault,    // Server cannot serve for another cause
   input  wire logic              map_src_ok,   // Object named by a mapping value is mappable
   input  wire logic              pdo_req,      // Process data message request, one cycle
   input  wire logic              pdo_tx,       // 1 selects transmit mappings, 0 receive
   input  wire logic [2:0]        pdo_map,      // Mapping number 0 to 7
   input  wire logic [63:0]       pdo_payload,  // Raw process data
   output logic                   resp_valid,   // Reply frame present, one cycle
   output logic                   resp_abort,   // Reply is an abort frame
   output logic [63:0]            resp_data,    // Reply bytes, byte 0 in [7:0]
   output logic                   wr_valid,     // Accepted expedited write, one cycle
   output logic [15:0]            wr_index,     // Index of the write
   output logic [7:0]             wr_sub,       // Subindex of the write
   output logic [31:0]            wr_value,     // Value of the write
   output logic                   pdo_valid,    // Process data message, one cycle
   output logic [3:0]             pdo_len,      // Payload length in bytes
   output logic [63:0]            pdo_data      // Payload, unused bytes zero
);
   import sap_pkg::*;

   //=======================================================================
   // State
   typedef struct packed
   {
      logic                       seg_act;
      logic                       seg_dl;
      logic                       tog;
      logic [15:0][8:0]           map_bits;
      logic                       resp_valid;
      logic                       resp_abort;
      logic [63:0]                resp_data;
      logic                       wr_valid;
      logic [15:0]                wr_index;
      logic [7:0]                 wr_sub;
      logic [31:0]                wr_value;
      logic                       pdo_valid;
      logic [3:0]                 pdo_len;
      logic [63:0]                pdo_data;
   } sap_state_t;

   sap_state_t  st_reg;
   sap_state_t  st_next;
   logic [1:0]  rst_sync_reg;
   logic        rst_n;

   // Decoded request fields
   logic [2:0]  ccs;
   logic [15:0] idx;
   logic [7:0]  sub;
   logic [31:0] val;
   logic        tog_in;
   logic        expd;
   logic [2:0]  dl_len;
   logic        is_map;
   logic [3:0]  mslot;
   logic [8:0]  map_sum;
   logic [31:0] code;
   logic [3:0]  plen;

   //=======================================================================
   // Functions
   // Abort frame: command, index, subindex, code least significant first
   function automatic logic [63:0] abort_frame(input logic [15:0] i, input logic [7:0] s,
                                               input logic [31:0] c);
      abort_frame = {c, s, i, SAP_CMD_ABORT};
   endfunction

   // Reply frame echoing index and subindex
   function automatic logic [63:0] ack_frame(input logic [7:0] cmd, input logic [15:0] i,
                                             input logic [7:0] s);
      ack_frame = {32'h0000_0000, s, i, cmd};
   endfunction

   // Process data communication or mapping parameter objects
   function automatic logic pdo_param(input logic [15:0] i);
      pdo_param = (i[15:12] == SAP_PDO_GRP) && (i[7:3] == 5'h00) &&
                  (i[11:8] == 4'h4 || i[11:8] == 4'h6 || i[11:8] == 4'h8 || i[11:8] == 4'ha);
   endfunction

   //=======================================================================
   // Reset release; the raw pin only feeds the synchroniser
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   //=======================================================================
   // Field extraction
   assign ccs    = req_data[7:5];
   assign tog_in = req_data[SAP_TOG_BIT];
   assign expd   = req_data[1];
   assign idx    = req_data[23:8];
   assign sub    = req_data[31:24];
   assign val    = req_data[63:32];
   assign dl_len = 3'h4 - {1'b0, req_data[3:2]};
   assign is_map = (idx[15:8] == SAP_MAP_RX_HI || idx[15:8] == SAP_MAP_TX_HI) &&
                   (idx[7:3] == 5'h00);
   assign mslot  = {idx[11], idx[2:0]};
   assign map_sum = st_reg.map_bits[mslot] + {1'b0, val[7:0]}; // Bit length in low byte

   //=======================================================================
   // Cause selection; first match wins, so a request reports one cause
   always_comb
   begin
      code = 32'h0000_0000;
      if (ccs > SAP_CCS_ABORT)
         code = SAP_AB_CMD;
      else if (ccs == SAP_CCS_DL_SEG || ccs == SAP_CCS_UL_SEG)
      begin
         // A segment outside a matching open transfer has no better cause
         if (!st_reg.seg_act || st_reg.seg_dl != (ccs == SAP_CCS_DL_SEG))
            code = SAP_AB_GENERAL;
         else if (tog_in != st_reg.tog)
            code = SAP_AB_TOGGLE;
      end
      else if (ccs != SAP_CCS_ABORT)
      begin
         if (!obj_idx_ok)
            code = SAP_AB_NO_OBJ;
         else if (!obj_sub_ok)
            code = SAP_AB_NO_SUB;
         else if (ccs == SAP_CCS_DL_INIT)
         begin
            if (obj_ro)
               code = SAP_AB_RDONLY;
            else if (pdo_param(idx) && nmt_state == SAP_NMT_OPER)
               code = SAP_AB_STATE;
            else if (expd && req_data[0] && obj_size != 3'h0 && dl_len > obj_size)
               code = SAP_AB_LONG;
            else if (expd && req_data[0] && obj_size != 3'h0 && dl_len < obj_size)
               code = SAP_AB_SHORT;
            else if (obj_fault)
               code = SAP_AB_GENERAL;
            else if (expd && idx == SAP_ERRCNT_IDX && sub == 8'h00 && val != 32'h0)
               code = SAP_AB_HIGH;
            else if (expd && obj_ranged && val > obj_max)
               code = SAP_AB_HIGH;
            else if (expd && obj_ranged && val < obj_min)
               code = SAP_AB_LOW;
            else if (expd && is_map && sub != 8'h00 && sub <= SAP_MAP_SUB_MAX && !map_src_ok)
               code = SAP_AB_NO_MAP;
            else if (expd && is_map && sub != 8'h00 && sub <= SAP_MAP_SUB_MAX &&
                     map_sum > SAP_MAP_MAX_BITS)
               code = SAP_AB_MAP_FULL;
         end
         else if (obj_fault)
            code = SAP_AB_GENERAL;
      end
   end

   // Bytes needed by the selected mapping, rounded up to whole bytes
   always_comb
   begin
      plen = 4'(({1'b0, st_reg.map_bits[{pdo_tx, pdo_map}]} + 10'h007) >> 3);
      if (plen > SAP_PDO_MAX_LEN)
         plen = SAP_PDO_MAX_LEN;
   end

   //=======================================================================
   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.resp_valid = 1'b0;
      st_next.wr_valid = 1'b0;
      st_next.pdo_valid = 1'b0;
      if (req_valid && ccs == SAP_CCS_ABORT)
      begin
         // Client abort: transfer ends silently, next one starts from scratch
         st_next.seg_act = 1'b0;
         st_next.tog = 1'b0;
      end
      else if (req_valid && code != 32'h0)
      begin
         st_next.resp_valid = 1'b1;
         st_next.resp_abort = 1'b1;
         st_next.resp_data = abort_frame(idx, sub, code);
         st_next.seg_act = 1'b0;
         st_next.tog = 1'b0;
      end
      else if (req_valid)
      begin
         st_next.resp_valid = 1'b1;
         st_next.resp_abort = 1'b0;
         unique case (ccs)
            SAP_CCS_DL_INIT:
            begin
               st_next.resp_data = ack_frame(SAP_CMD_DL_ACK, idx, sub);
               st_next.seg_act = !expd;
               st_next.seg_dl = 1'b1;
               st_next.tog = 1'b0;
               if (expd)
               begin
                  // Only a write that passed every check reaches the dictionary
                  st_next.wr_valid = 1'b1;
                  st_next.wr_index = idx;
                  st_next.wr_sub = sub;
                  st_next.wr_value = val;
                  if (is_map && sub == 8'h00 && val == 32'h0)
                     st_next.map_bits[mslot] = 9'h000;
                  else if (is_map && sub != 8'h00 && sub <= SAP_MAP_SUB_MAX)
                     st_next.map_bits[mslot] = map_sum;
               end
            end
            SAP_CCS_UL_INIT:
            begin
               st_next.resp_data = ack_frame(SAP_CMD_UL_ACK, idx, sub);
               st_next.seg_act = (obj_size == 3'h0);
               st_next.seg_dl = 1'b0;
               st_next.tog = 1'b0;
            end
            SAP_CCS_DL_SEG:
            begin
               st_next.resp_data = {56'h0, SAP_CMD_DSEG_ACK | {3'h0, st_reg.tog, 4'h0}};
               st_next.tog = !st_reg.tog;
               st_next.seg_act = !req_data[0]; // Last segment closes the transfer
            end
            default:
            begin
               st_next.resp_data = {56'h0, SAP_CMD_USEG_ACK | {3'h0, st_reg.tog, 4'h0}};
               st_next.tog = !st_reg.tog;
            end
         endcase
      end
      // Process data framing: payload only, length from the mapping
      if (pdo_req && nmt_state == SAP_NMT_OPER)
      begin
         st_next.pdo_valid = 1'b1;
         st_next.pdo_len = plen;
         for (int b = 0; b < 8; b++)
            st_next.pdo_data[b*8 +: 8] = (4'(b) < plen) ? pdo_payload[b*8 +: 8] : 8'h00;
      end
   end

   //=======================================================================
   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Outputs straight from the state register
   assign resp_valid = st_reg.resp_valid;
   assign resp_abort = st_reg.resp_abort;
   assign resp_data  = st_reg.resp_data;
   assign wr_valid   = st_reg.wr_valid;
   assign wr_index   = st_reg.wr_index;
   assign wr_sub     = st_reg.wr_sub;
   assign wr_value   = st_reg.wr_value;
   assign pdo_valid  = st_reg.pdo_valid;
   assign pdo_len    = st_reg.pdo_len;
   assign pdo_data   = st_reg.pdo_data;

   //=======================================================================
   // Checks
   a_abort_frame: assert property (
      @(posedge clk) disable iff (!rst_n)
      resp_valid && resp_abort |-> resp_data[7:0] == 8'h80)
      else $error("abort frame lacks command 80h");

   a_unknown_cmd: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] > 3'h4 |=> resp_abort && resp_data[63:32] == 32'h0504_0001)
      else $error("unknown command not aborted");

   a_missing_index: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] inside {3'h1, 3'h2} && !obj_idx_ok
      |=> resp_valid && resp_data[63:32] == 32'h0602_0000 &&
      resp_data[31:8] == $past(req_data[31:8]))
      else $error("missing index not aborted");

   a_missing_sub: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] inside {3'h1, 3'h2} && obj_idx_ok && !obj_sub_ok
      |=> resp_data[63:32] == 32'h0609_0011)
      else $error("missing subindex not aborted");

   a_readonly_kept: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] == 3'h1 && obj_idx_ok && obj_sub_ok && obj_ro
      |=> !wr_valid && resp_abort && resp_data[63:32] == 32'h0601_0002)
      else $error("read-only write not refused");

   a_toggle_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      resp_valid && resp_abort |-> !st_reg.tog && !st_reg.seg_act)
      else $error("toggle not restarted after abort");

   a_pdo_gated: assert property (
      @(posedge clk) disable iff (!rst_n)
      pdo_req ##1 pdo_valid |-> $past(nmt_state) == SAP_NMT_OPER)
      else $error("process data outside operational state");

   a_pdo_length: assert property (
      @(posedge clk) disable iff (!rst_n)
      pdo_valid |-> pdo_len <= 4'h8 && (pdo_len == 4'h8 || pdo_data >> {pdo_len, 3'h0} == 64'h0))
      else $error("process data longer than allowed");

   a_pdo_state: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] == 3'h1 && req_data[23:20] == 4'h1 && req_data[15:11] == 5'h00
      && req_data[19:16] inside {4'h4, 4'h6, 4'h8, 4'ha} && obj_idx_ok && obj_sub_ok && !obj_ro
      && nmt_state == SAP_NMT_OPER |=> resp_data[63:32] == 32'h0800_0022 && !wr_valid)
      else $error("parameter write allowed while operational");

   a_toggle_check: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] == 3'h0 && st_reg.seg_act && st_reg.seg_dl &&
      tog_in != st_reg.tog |=> resp_abort && resp_data[63:32] == 32'h0503_0000)
      else $error("repeated toggle kept");

   a_length_long: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:0] == 8'h23 && obj_idx_ok && obj_sub_ok && !obj_ro &&
      !pdo_param(idx) && obj_size == 3'h1 |=> resp_data[63:32] == 32'h0607_0012)
      else $error("long write kept");

   a_errcnt_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      req_valid && req_data[7:5] == 3'h1 && req_data[1] && idx == SAP_ERRCNT_IDX &&
      sub == 8'h00 && val != 32'h0 |=> !wr_valid)
      else $error("error count write kept");
endmodule
`default_nettype wire

//--- inc/sap_pkg.sv
// Constants and types shared by the object access checker
//==========================================================================
// Behaviour
// - A failed request is answered by an abort frame carrying a 32-bit cause code.
// - Segment request whose toggle bit did not alternate aborts with 05030000.
// - Unknown command specifier in byte 0 aborts with 05040001.
// - Download to a read-only object aborts with 06010002, object stays unchanged.
// - Access to a missing index aborts with 06020000.
// - Mapping an object not allowed in process data aborts with 06040041.
// - Mapping that would exceed eight bytes aborts with 06040042.
// - Write with more bytes than the object size aborts with 06070012.
// - Write with fewer bytes than the object size aborts with 06070013.
// - Existing index with missing subindex aborts with 06090011.
// - Value above a ranged object's maximum aborts with 06090031.
// - Error count entry 1003:00 accepts only zero, else value-too-great abort.
// - Value below a ranged object's minimum aborts with 06090032.
// - Failures without a specific cause abort with 08000000.
// - Process data parameter writes while Operational abort with 08000022.
// - Process data flows only while Operational; master configures in Pre-Operational.
// - Eight independent mappings are kept for each direction.
// - A process data message carries at most eight data bytes.
// - Process data is bare payload, placed only by the stored mapping.
// - Abort frame is command 80h, index, subindex, code; transfer ends unconfirmed.
// - Toggle starts at zero for every new transfer, also after an abort.
//==========================================================================
`default_nettype none
package sap_pkg;
   // Network management states as seen by this block
   typedef enum logic [1:0] {SAP_NMT_INIT, SAP_NMT_PREOP, SAP_NMT_OPER, SAP_NMT_STOP} sap_nmt_t;

   // Abort codes
   localparam logic [31:0] SAP_AB_TOGGLE   = 32'h0503_0000;
   localparam logic [31:0] SAP_AB_CMD      = 32'h0504_0001;
   localparam logic [31:0] SAP_AB_RDONLY   = 32'h0601_0002;
   localparam logic [31:0] SAP_AB_NO_OBJ   = 32'h0602_0000;
   localparam logic [31:0] SAP_AB_NO_MAP   = 32'h0604_0041;
   localparam logic [31:0] SAP_AB_MAP_FULL = 32'h0604_0042;
   localparam logic [31:0] SAP_AB_LONG     = 32'h0607_0012;
   localparam logic [31:0] SAP_AB_SHORT    = 32'h0607_0013;
   localparam logic [31:0] SAP_AB_NO_SUB   = 32'h0609_0011;
   localparam logic [31:0] SAP_AB_HIGH     = 32'h0609_0031;
   localparam logic [31:0] SAP_AB_LOW      = 32'h0609_0032;
   localparam logic [31:0] SAP_AB_GENERAL  = 32'h0800_0000;
   localparam logic [31:0] SAP_AB_STATE    = 32'h0800_0022;

   // Client command specifiers (byte 0 bits 7:5)
   localparam logic [2:0]  SAP_CCS_DL_SEG  = 3'h0;
   localparam logic [2:0]  SAP_CCS_DL_INIT = 3'h1;
   localparam logic [2:0]  SAP_CCS_UL_INIT = 3'h2;
   localparam logic [2:0]  SAP_CCS_UL_SEG  = 3'h3;
   localparam logic [2:0]  SAP_CCS_ABORT   = 3'h4;

   // Server reply command bytes (toggle inserted at bit 4)
   localparam logic [7:0]  SAP_CMD_ABORT   = 8'h80;
   localparam logic [7:0]  SAP_CMD_DL_ACK  = 8'h60;
   localparam logic [7:0]  SAP_CMD_DSEG_ACK = 8'h20;
   localparam logic [7:0]  SAP_CMD_UL_ACK  = 8'h40;
   localparam logic [7:0]  SAP_CMD_USEG_ACK = 8'h00;
   localparam int          SAP_TOG_BIT     = 4;

   // Object dictionary landmarks
   localparam logic [15:0] SAP_ERRCNT_IDX  = 16'h1003;
   localparam logic [7:0]  SAP_MAP_RX_HI   = 8'h16;
   localparam logic [7:0]  SAP_MAP_TX_HI   = 8'h1a;
   localparam logic [3:0]  SAP_PDO_GRP     = 4'h1;
   localparam logic [7:0]  SAP_MAP_SUB_MAX = 8'h08;

   // Process data limits
   localparam int          SAP_NUM_MAP     = 8;
   localparam logic [8:0]  SAP_MAP_MAX_BITS = 9'h040;
   localparam logic [3:0]  SAP_PDO_MAX_LEN = 4'h8;
endpackage
`default_nettype wire

//--- tb/sap_master_model.sv
// Client side model that issues object server requests and collects the replies
`default_nettype none
module sap_master_model
(
   input  wire logic        clk,        // Device clock
   output logic             req_valid,  // Request strobe
   output logic [63:0]      req_data,   // Request frame
   input  wire logic        resp_valid, // Reply strobe
   input  wire logic        resp_abort, // Reply is an abort frame
   input  wire logic [63:0] resp_data   // Reply frame
);
   timeunit 1ns;
   timeprecision 1ns;
   //==========================================================================
   // Request issue
   initial
   begin
      req_valid = 1'b0;
      req_data  = 64'h0;
   end
   // One frame per call; the reply stands one cycle, so it is taken right after its edge.
   // The released bus shows the inverse frame so a stale frame never looks live.
   task automatic xfer(input logic [63:0] f, output logic v, output logic ab,
                       output logic [63:0] rd);
      @(posedge clk);
      #5;
      req_valid = 1'b1;
      req_data  = f;
      @(posedge clk);
      #5;
      req_valid = 1'b0;
      req_data  = ~f;
      v         = resp_valid;
      ab        = resp_abort;
      rd        = resp_data;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the object access checker
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sap_pkg::*;
   //==========================================================================
   // Signals
   logic        clk, arst_n, req_valid, obj_idx_ok, obj_sub_ok, obj_ro, obj_ranged;
   logic        obj_fault, map_src_ok, pdo_req, pdo_tx, resp_valid, resp_abort;
   logic        wr_valid, pdo_valid, v, ab;
   sap_nmt_t    nmt_state;
   logic [2:0]  obj_size, pdo_map;
   logic [31:0] obj_min, obj_max, wr_value;
   logic [63:0] req_data, pdo_payload, resp_data, pdo_data, rd;
   logic [15:0] wr_index;
   logic [7:0]  wr_sub;
   logic [3:0]  pdo_len;
   int          fails = 0;
   int          total_checks = 0;
   //==========================================================================
   // Instances
   sap_checker i_dut (.clk(clk), .arst_n(arst_n), .nmt_state(nmt_state),
      .req_valid(req_valid), .req_data(req_data), .obj_idx_ok(obj_idx_ok),
      .obj_sub_ok(obj_sub_ok), .obj_ro(obj_ro), .obj_size(obj_size), .obj_ranged(obj_ranged),
      .obj_min(obj_min), .obj_max(obj_max), .obj_fault(obj_fault), .map_src_ok(map_src_ok),
      .pdo_req(pdo_req), .pdo_tx(pdo_tx), .pdo_map(pdo_map), .pdo_payload(pdo_payload),
      .resp_valid(resp_valid), .resp_abort(resp_abort), .resp_data(resp_data),
      .wr_valid(wr_valid), .wr_index(wr_index), .wr_sub(wr_sub), .wr_value(wr_value),
      .pdo_valid(pdo_valid), .pdo_len(pdo_len), .pdo_data(pdo_data));
   sap_master_model i_master (.clk(clk), .req_valid(req_valid), .req_data(req_data),
      .resp_valid(resp_valid), .resp_abort(resp_abort), .resp_data(resp_data));
   // 20 MHz clock
   always #25 clk = ~clk;
   //==========================================================================
   // Helpers
   task automatic cmp(input bit ok, input string msg);
      total_checks++;
      if (!ok)
      begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   function automatic logic [63:0] frm(input logic [7:0] c, input logic [15:0] i,
                                       input logic [7:0] s, input logic [31:0] d);
      return {d, s, i, c};
   endfunction
   // Dictionary entry descriptor
   task automatic obj(input logic io, so, r, input logic [2:0] sz, input logic rg, f, m);
      obj_idx_ok = io;
      obj_sub_ok = so;
      obj_ro     = r;
      obj_size   = sz;
      obj_ranged = rg;
      obj_fault  = f;
      map_src_ok = m;
   endtask
   // Abort reply must carry 80h, the code in bytes 4..7, and no write may leak
   task automatic ex_ab(input logic [63:0] f, input logic [31:0] code);
      i_master.xfer(f, v, ab, rd);
      cmp(v === 1'b1 && ab === 1'b1 && rd[7:0] === SAP_CMD_ABORT, "no abort");
      cmp(rd[63:32] === code, "abort code");
      if (f[7:5] != SAP_CCS_DL_SEG)
         cmp(rd[31:8] === f[31:8], "abort address echo");
      cmp(wr_valid === 1'b0, "write leaked");
   endtask
   task automatic ex_ok(input logic [63:0] f, input logic [7:0] c);
      i_master.xfer(f, v, ab, rd);
      cmp(v === 1'b1 && ab === 1'b0 && rd[7:0] === c, "reply kind");
      if (c === SAP_CMD_DL_ACK && f[1])
         cmp(wr_valid === 1'b1 && wr_index === f[23:8] && wr_sub === f[31:24] &&
             wr_value === f[63:32], "write");
   endtask
   // Process data request; unused payload bytes must read zero
   task automatic ex_pdo(input logic tx, input logic [2:0] m, input logic [3:0] n,
                         input logic ev);
      logic [63:0] msk;
      msk = (64'h1 << (8 * n)) - 64'h1;
      @(posedge clk);
      #5;
      pdo_req     = 1'b1;
      pdo_tx      = tx;
      pdo_map     = m;
      pdo_payload = 64'h8877_6655_4433_2211;
      @(posedge clk);
      #5;
      pdo_req     = 1'b0;
      pdo_payload = ~pdo_payload;
      cmp(pdo_valid === ev, "pdo strobe");
      if (ev)
         cmp(pdo_len === n && pdo_data === (64'h8877_6655_4433_2211 & msk), "pdo body");
   endtask
   //==========================================================================
   // Scenarios
   task automatic t_addr();
      for (int c = 5; c < 8; c++)
         ex_ab(frm({c[2:0], 5'h0}, 16'h2000, 8'h0, 32'h0), SAP_AB_CMD);
      obj(0, 0, 0, 3'h1, 0, 0, 1);
      ex_ab(frm(8'h40, 16'h2100, 8'h0, 32'h0), SAP_AB_NO_OBJ);
      obj(1, 0, 0, 3'h1, 0, 0, 1);
      ex_ab(frm(8'h2f, 16'h2000, 8'h7, 32'h5), SAP_AB_NO_SUB);
      obj(1, 1, 1, 3'h1, 0, 0, 1);
      ex_ab(frm(8'h2f, 16'h2000, 8'h0, 32'h5), SAP_AB_RDONLY);
      obj(1, 1, 0, 3'h1, 0, 1, 1);
      ex_ab(frm(8'h2f, 16'h2000, 8'h0, 32'h5), SAP_AB_GENERAL);
   endtask
   task automatic t_len();
      obj(1, 1, 0, 3'h1, 0, 0, 1);
      ex_ab(frm(8'h23, 16'h2000, 8'h0, 32'h5), SAP_AB_LONG);
      obj(1, 1, 0, 3'h4, 0, 0, 1);
      ex_ab(frm(8'h2f, 16'h2000, 8'h0, 32'h5), SAP_AB_SHORT);
      ex_ab(frm(8'h27, 16'h2000, 8'h0, 32'h5), SAP_AB_SHORT);
      ex_ok(frm(8'h23, 16'h2000, 8'h0, 32'h5), SAP_CMD_DL_ACK);
   endtask
   task automatic t_range();
      obj(1, 1, 0, 3'h4, 1, 0, 1);
      ex_ab(frm(8'h23, 16'h2001, 8'h0, 32'd21), SAP_AB_HIGH);
      ex_ab(frm(8'h23, 16'h2001, 8'h0, 32'd9), SAP_AB_LOW);
      ex_ok(frm(8'h23, 16'h2001, 8'h0, 32'd20), SAP_CMD_DL_ACK);
      ex_ok(frm(8'h23, 16'h2001, 8'h0, 32'd10), SAP_CMD_DL_ACK);
      obj(1, 1, 0, 3'h1, 0, 0, 1);
      ex_ab(frm(8'h2f, SAP_ERRCNT_IDX, 8'h0, 32'h1), SAP_AB_HIGH);
      ex_ok(frm(8'h2f, SAP_ERRCNT_IDX, 8'h0, 32'h0), SAP_CMD_DL_ACK);
   endtask
   task automatic t_state();
      logic [15:0] ids [5] = '{16'h1400, 16'h1407, 16'h1600, 16'h1807, 16'h1a07};
      obj(1, 1, 0, 3'h4, 0, 0, 1);
      nmt_state = SAP_NMT_OPER;
      foreach (ids[k])
         ex_ab(frm(8'h23, ids[k], 8'h0, 32'h0), SAP_AB_STATE);
      ex_ok(frm(8'h23, 16'h1408, 8'h0, 32'h0), SAP_CMD_DL_ACK);
      nmt_state = SAP_NMT_STOP;
      ex_ok(frm(8'h23, 16'h1a00, 8'h0, 32'h0), SAP_CMD_DL_ACK);
      nmt_state = SAP_NMT_PREOP;
      foreach (ids[k])
         ex_ok(frm(8'h23, ids[k], 8'h0, 32'h0), SAP_CMD_DL_ACK);
   endtask
   // Mappings are set up in Pre-Operational only, as the master must
   task automatic t_map();
      nmt_state = SAP_NMT_PREOP;
      obj(1, 1, 0, 3'h4, 0, 0, 1);
      ex_ok(frm(8'h23, 16'h1600, 8'h1, 32'h6040_0020), SAP_CMD_DL_ACK);
      ex_ok(frm(8'h23, 16'h1600, 8'h2, 32'h607a_0020), SAP_CMD_DL_ACK);
      ex_ab(frm(8'h23, 16'h1600, 8'h3, 32'h6041_0008), SAP_AB_MAP_FULL);
      obj(1, 1, 0, 3'h4, 0, 0, 0);
      ex_ab(frm(8'h23, 16'h1a07, 8'h1, 32'h6041_0010), SAP_AB_NO_MAP);
      obj(1, 1, 0, 3'h4, 0, 0, 1);
      ex_ok(frm(8'h23, 16'h1a07, 8'h1, 32'h6041_0010), SAP_CMD_DL_ACK);
      ex_ok(frm(8'h23, 16'h1a07, 8'h2, 32'h6061_0008), SAP_CMD_DL_ACK);
      ex_pdo(1'b0, 3'h0, 4'h8, 1'b0);
      nmt_state = SAP_NMT_OPER;
      ex_pdo(1'b0, 3'h0, 4'h8, 1'b1);
      ex_pdo(1'b1, 3'h7, 4'h3, 1'b1);
      nmt_state = SAP_NMT_PREOP;
   endtask
   // Segmented transfers; a repeated toggle aborts, the next starts at zero
   task automatic t_seg();
      obj(1, 1, 0, 3'h0, 0, 0, 1);
      ex_ok(frm(8'h21, 16'h2002, 8'h0, 32'd14), SAP_CMD_DL_ACK);
      ex_ok(64'h0, SAP_CMD_DSEG_ACK);
      ex_ok(64'h10, SAP_CMD_DSEG_ACK | 8'h10);
      ex_ab(64'h10, SAP_AB_TOGGLE);
      ex_ok(frm(8'h21, 16'h2002, 8'h0, 32'd14), SAP_CMD_DL_ACK);
      ex_ok(64'h0, SAP_CMD_DSEG_ACK);
      ex_ok(64'h11, SAP_CMD_DSEG_ACK | 8'h10);
      ex_ab(64'h0, SAP_AB_GENERAL);
      ex_ok(frm(8'h21, 16'h2002, 8'h0, 32'd14), SAP_CMD_DL_ACK);
      i_master.xfer(frm(SAP_CMD_ABORT, 16'h2002, 8'h0, SAP_AB_GENERAL), v, ab, rd);
      cmp(v === 1'b0, "reply to client abort");
      ex_ok(frm(8'h21, 16'h2002, 8'h0, 32'd14), SAP_CMD_DL_ACK);
      ex_ok(64'h0, SAP_CMD_DSEG_ACK);
      ex_ok(frm(8'h40, 16'h2002, 8'h0, 32'h0), SAP_CMD_UL_ACK);
      ex_ok(64'h60, SAP_CMD_USEG_ACK);
      ex_ab(64'h60, SAP_AB_TOGGLE);
   endtask
   //==========================================================================
   // Verdict and run control
   task automatic results();
      $display("checks %0d, fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("mismatch at %0t: run did not finish", $time);
      results();
   end
   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      nmt_state = SAP_NMT_PREOP;
      obj_min = 32'd10;
      obj_max = 32'd20;
      pdo_req = 1'b0;
      pdo_tx = 1'b0;
      pdo_map = 3'h0;
      pdo_payload = 64'h0;
      obj(1, 1, 0, 3'h1, 0, 0, 1);
      repeat (4) @(posedge clk);
      #5;
      arst_n = 1'b1;
      // Internal reset clears two edges after release
      repeat (3) @(posedge clk);
      t_addr();
      t_len();
      t_range();
      t_state();
      t_map();
      t_seg();
      results();
   end
endmodule
`default_nettype wire
